// ### design/tdm_bit_defines.svh
// Purpose: constants for the tdm channel bit processing ends
// Assumes: included by bare name
// Notes:   offsets, fields, reset values and timing counts
`ifndef TDM_BIT_DEFINES_SVH
`define TDM_BIT_DEFINES_SVH
// ****************************************
// device register kinds
// ****************************************
`define KIND_MODE      3'h0
`define KIND_CTRL      3'h1
`define KIND_START     3'h2
`define KIND_LEN       3'h3
`define KIND_ERR       3'h4
`define KIND_QUAD      3'h5
`define KIND_RATE      3'h6
// ****************************************
// fields and reset values
// ****************************************
`define CHK_ALL_BIT    5
`define GEN_ALL_BIT    4
`define CTRL_CLR_BIT   1
`define CTRL_EN_BIT    0
`define PCC_PATTERN    2'h2
`define ERR_MAX        16'hFFFF
`define MODE_RST       16'h0000
`define LEN_RST        9'h001
`define PRBS_SEED      15'h7FFF
`define CHK_PRIME      2'h2
`define ABI_MASK       8'h55
`define IABI_MASK      8'hAA
`define MI_MASK        8'h7F
`define ALL_MASK       8'hFF
// ****************************************
// timing and host registers
// ****************************************
`define FRAME_US       125
`define SETTLE_US      250
`define SETTLE_FRAMES  2'((`SETTLE_US + `FRAME_US - 1) / `FRAME_US)
`define OFS_CMD        8'h00
`define OFS_WDATA      8'h04
`define OFS_RDATA      8'h08
`define OFS_STATUS     8'h0C
`endif

// ### design/tdm_bit_pkg.sv
// Purpose: shared types of the tdm channel bit processing ends
// Assumes: nothing
// Notes:   constants live in tdm_bit_defines.svh
package tdm_bit_pkg;
	typedef logic [14:0] lfsr_t;
	typedef logic [7:0]  byte_t;
	typedef enum logic [3:0] {
		H_IDLE  = 4'b0001,
		H_GUARD = 4'b0010,
		H_ISSUE = 4'b0100,
		H_WAIT  = 4'b1000
	} host_state_e;
endpackage : tdm_bit_pkg

// ### design/tdm_bit_if.sv
// Purpose: link between the processing device and its host side
// Assumes: both ends on core_clk
// Notes:   one slot per cycle, one register op at a time
`timescale 1ns/1ps
`default_nettype none
interface tdm_bit_if;
	logic        slot_valid;
	logic [4:0]  slot_stream;
	logic [7:0]  slot_channel;
	logic [7:0]  rx_byte;
	logic [7:0]  sw_byte;
	logic [2:0]  conn_low;
	logic [4:0]  conn_high;
	logic        out_valid;
	logic [4:0]  out_stream;
	logic [7:0]  out_channel;
	logic [7:0]  tx_byte;
	logic [7:0]  rx_forced;
	logic        reg_req;
	logic        reg_wr;
	logic [2:0]  reg_kind;
	logic [4:0]  reg_stream;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        reg_ack;
	modport dev (input slot_valid, slot_stream, slot_channel, rx_byte, sw_byte, conn_low,
		conn_high, reg_req, reg_wr, reg_kind, reg_stream, reg_wdata,
		output out_valid, out_stream, out_channel, tx_byte, rx_forced, reg_rdata, reg_ack);
	modport host (output slot_valid, slot_stream, slot_channel, rx_byte, sw_byte, conn_low,
		conn_high, reg_req, reg_wr, reg_kind, reg_stream, reg_wdata,
		input out_valid, out_stream, out_channel, tx_byte, rx_forced, reg_rdata, reg_ack);
endinterface : tdm_bit_if
`default_nettype wire

// ### design/tdm_bit_device.sv
// Purpose: per-stream pattern test, law translation, quadrant forcing
// Assumes: one channel slot per cycle, time-shared over 32 streams
// Notes:   results leave one cycle after the slot
`timescale 1ns/1ps
`default_nettype none
`include "tdm_bit_defines.svh"
module tdm_bit_device (
	input  wire logic core_clk,
	input  wire logic srst,
	tdm_bit_if.dev    lnk
);
	// ****************************************
	// shared mode and per-stream state
	// ****************************************
	logic [15:0]         mode;
	logic [1:0]          ctrl     [32];
	logic [7:0]          start    [32];
	logic [8:0]          len      [32];
	logic [15:0]         errcnt   [32];
	logic [11:0]         quad     [32];
	logic [1:0]          rate     [32];
	tdm_bit_pkg::lfsr_t  gen_st   [32];
	tdm_bit_pkg::lfsr_t  chk_st   [32];
	logic [1:0]          prime    [32];
	logic [4:0]          s;
	logic                pat_sel;
	logic                chk_act;
	logic                in_win;
	logic [8:0]          wdiff;
	logic [22:0]         gen_res;
	logic [18:0]         chk_res;
	logic [1:0]          qi;
	logic [2:0]          qcode;
	logic [2:0]          qsh;
	logic [16:0]         next_err;
	logic                wr;
	tdm_bit_pkg::byte_t  forced;

	// ****************************************
	// pattern and law functions
	// ****************************************
	function automatic logic [22:0] gen8(input tdm_bit_pkg::lfsr_t st);
		tdm_bit_pkg::lfsr_t t;
		logic [7:0]         b;
		logic               fb;
		t = st;
		b = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			fb = t[14] ^ t[13];
			b[i] = fb;
			t = {t[13:0], fb};
		end
		return {t, b};
	endfunction : gen8

	// self-synchronising compare of eight received bits
	function automatic logic [18:0] chk8(input tdm_bit_pkg::lfsr_t st, input logic [7:0] r);
		tdm_bit_pkg::lfsr_t t;
		logic [3:0]         e;
		t = st;
		e = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			e = e + {3'h0, r[i] ^ t[14] ^ t[13]};
			t = {t[13:0], r[i]};
		end
		return {t, e};
	endfunction : chk8

	function automatic logic [15:0] expand(input logic mu, input logic [6:0] c);
		logic [15:0] m;
		m = {12'h000, c[3:0]} << 4;
		if (mu)
			return (((m >> 1) + 16'h0084) << c[6:4]) - 16'h0084;
		else if (c[6:4] == 3'h0)
			return m + 16'h0008;
		else
			return (m + 16'h0108) << (c[6:4] - 3'h1);
	endfunction : expand

	function automatic logic [6:0] compress(input logic mu, input logic [15:0] mag);
		logic [15:0] m;
		logic [2:0]  seg;
		m = mu ? ((mag > 16'h7F7B) ? 16'h7FFF : mag + 16'h0084) : mag;
		seg = 3'h0;
		for (int i = 0; i < 7; i++) begin
			if (m >= (16'h0100 << i))
				seg = seg + 3'h1;
		end
		if (!mu && seg == 3'h0)
			return {seg, 4'(m >> 4)};
		return {seg, 4'(m >> (seg + 3'h3))};
	endfunction : compress

	function automatic logic [7:0] vmask(input logic [1:0] c);
		unique case (c)
			2'h0: return `ABI_MASK;
			2'h1: return `MI_MASK;
			2'h2: return 8'h00;
			2'h3: return 8'h00;
		endcase
	endfunction : vmask

	function automatic logic [7:0] dmask(input logic [1:0] c);
		unique case (c)
			2'h0: return 8'h00;
			2'h1: return `ABI_MASK;
			2'h2: return `IABI_MASK;
			2'h3: return `ALL_MASK;
		endcase
	endfunction : dmask

	function automatic logic [7:0] xlate(input logic [7:0] b, input logic [4:0] hi);
		logic [7:0] r;
		r = b ^ vmask(hi[3:2]);
		if (hi[3:2] == hi[1:0])
			return b;
		if (hi[4])
			return b ^ dmask(hi[3:2]) ^ dmask(hi[1:0]);
		if (hi[2] != hi[0])
			r = {r[7], compress(hi[0], expand(hi[2], r[6:0]))};
		return r ^ vmask(hi[1:0]);
	endfunction : xlate

	// ****************************************
	// slot decode
	// ****************************************
	always_comb begin
		s       = lnk.slot_stream;
		wr      = lnk.reg_req & lnk.reg_wr;
		pat_sel = lnk.conn_low[0] & (lnk.conn_low[2:1] == `PCC_PATTERN)
			& mode[`GEN_ALL_BIT];
		chk_act = mode[`CHK_ALL_BIT] & ctrl[s][`CTRL_EN_BIT];
		wdiff   = {1'b0, lnk.slot_channel} - {1'b0, start[s]};
		in_win  = (lnk.slot_channel >= start[s]) && (wdiff < len[s]);
		gen_res = gen8(gen_st[s]);
		chk_res = chk8(chk_st[s], lnk.rx_byte);
		qsh     = {1'b0, rate[s]} + 3'h3;
		qi      = 2'(lnk.slot_channel >> qsh);
		qcode   = quad[s][qi * 3 +: 3];
		forced  = lnk.rx_byte;
		if (qcode[2] && qcode[1])
			forced[7] = qcode[0];
		else if (qcode[2])
			forced[0] = qcode[0];
		next_err = {1'b0, errcnt[s]} + {13'h0000, chk_res[3:0]};
	end

	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst)
			mode <= `MODE_RST;
		else if (wr && lnk.reg_kind == `KIND_MODE)
			mode <= lnk.reg_wdata;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < 32; i++) begin
				ctrl[i]  <= 2'h0;
				start[i] <= 8'h00;
				len[i]   <= `LEN_RST;
				quad[i]  <= 12'h000;
				rate[i]  <= 2'h0;
			end
		end else if (wr) begin
			unique case (lnk.reg_kind)
				`KIND_CTRL:  ctrl[lnk.reg_stream]  <= lnk.reg_wdata[1:0];
				`KIND_START: start[lnk.reg_stream] <= lnk.reg_wdata[7:0];
				`KIND_LEN:   len[lnk.reg_stream]   <= lnk.reg_wdata[8:0];
				`KIND_QUAD:  quad[lnk.reg_stream]  <= lnk.reg_wdata[11:0];
				`KIND_RATE:  rate[lnk.reg_stream]  <= lnk.reg_wdata[1:0];
				default: ;
			endcase
		end
	end

	// register read answer, one cycle after the request
	always_ff @(posedge core_clk) begin
		if (srst) begin
			lnk.reg_ack   <= 1'b0;
			lnk.reg_rdata <= 16'h0000;
		end else begin
			lnk.reg_ack <= lnk.reg_req;
			unique case (lnk.reg_kind)
				`KIND_MODE:  lnk.reg_rdata <= mode;
				`KIND_CTRL:  lnk.reg_rdata <= {14'h0000, ctrl[lnk.reg_stream]};
				`KIND_START: lnk.reg_rdata <= {8'h00, start[lnk.reg_stream]};
				`KIND_LEN:   lnk.reg_rdata <= {7'h00, len[lnk.reg_stream]};
				`KIND_ERR:   lnk.reg_rdata <= errcnt[lnk.reg_stream];
				`KIND_QUAD:  lnk.reg_rdata <= {4'h0, quad[lnk.reg_stream]};
				`KIND_RATE:  lnk.reg_rdata <= {14'h0000, rate[lnk.reg_stream]};
				default:     lnk.reg_rdata <= 16'h0000;
			endcase
		end
	end

	// ****************************************
	// generators and checkers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < 32; i++)
				gen_st[i] <= `PRBS_SEED;
		end else if (lnk.slot_valid && pat_sel) begin
			gen_st[s] <= gen_res[22:8];
		end
	end

	// contiguous window assumed so the checker stays in step
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < 32; i++) begin
				chk_st[i] <= 15'h0000;
				prime[i]  <= 2'h0;
			end
		end else begin
			for (int i = 0; i < 32; i++)
				if (!ctrl[i][`CTRL_EN_BIT])
					prime[i] <= 2'h0;
			if (lnk.slot_valid && chk_act && in_win) begin
				chk_st[s] <= chk_res[18:4];
				if (prime[s] != `CHK_PRIME)
					prime[s] <= prime[s] + 2'h1;
			end
		end
	end

	// error count: clear bit held wins over counting
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < 32; i++)
				errcnt[i] <= 16'h0000;
		end else begin
			if (lnk.slot_valid && chk_act && in_win && prime[s] == `CHK_PRIME)
				errcnt[s] <= next_err[16] ? `ERR_MAX : next_err[15:0];
			for (int i = 0; i < 32; i++)
				if (ctrl[i][`CTRL_CLR_BIT])
					errcnt[i] <= 16'h0000;
		end
	end

	// ****************************************
	// output slot
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			lnk.out_valid   <= 1'b0;
			lnk.out_stream  <= 5'h00;
			lnk.out_channel <= 8'h00;
			lnk.tx_byte     <= 8'h00;
			lnk.rx_forced   <= 8'h00;
		end else begin
			lnk.out_valid   <= lnk.slot_valid;
			lnk.out_stream  <= s;
			lnk.out_channel <= lnk.slot_channel;
			lnk.tx_byte     <= pat_sel ? gen_res[7:0] : xlate(lnk.sw_byte, lnk.conn_high);
			lnk.rx_forced   <= forced;
		end
	end
endmodule : tdm_bit_device
`default_nettype wire

// ### design/tdm_bit_host.sv
// Purpose: host end: APB command port, slot source and sink
// Assumes: APB master on core_clk, zero wait states
// Notes:   guards checker enable and quadrant use per stream
`timescale 1ns/1ps
`default_nettype none
`include "tdm_bit_defines.svh"
module tdm_bit_host (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        frame_start,
	input  wire logic        cfg_done,
	input  wire logic        u_valid,
	input  wire logic [4:0]  u_stream,
	input  wire logic [7:0]  u_channel,
	input  wire logic [7:0]  u_rx_byte,
	input  wire logic [7:0]  u_sw_byte,
	input  wire logic [2:0]  u_conn_low,
	input  wire logic [4:0]  u_conn_high,
	output logic             d_valid,
	output logic [4:0]       d_stream,
	output logic [7:0]       d_channel,
	output logic [7:0]       d_tx_byte,
	output logic [7:0]       d_rx_forced,
	tdm_bit_if.host          lnk
);
	tdm_bit_pkg::host_state_e state;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [1:0]  settle;
	logic        refused;
	logic [31:0] quad_used;
	logic [31:0] chk_on;
	logic [1:0]  rate_sh [32];
	logic        cmd_wr;
	logic        bad;
	logic        en_req;
	logic [8:0]  max_len;

	// ****************************************
	// APB slave
	// ****************************************
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign cmd_wr  = psel & penable & pwrite & (paddr == `OFS_CMD) & (state == tdm_bit_pkg::H_IDLE);
	assign en_req  = (pwdata[2:0] == `KIND_CTRL) & pwdata[16] & wdata[`CTRL_EN_BIT];
	assign bad     = (en_req & quad_used[pwdata[12:8]])
		| ((pwdata[2:0] == `KIND_QUAD) & pwdata[16] & (wdata != 16'h0000) & chk_on[pwdata[12:8]]);
	assign max_len = 9'h020 << rate_sh[lnk.reg_stream];

	// read data set in the setup cycle
	always_ff @(posedge core_clk) begin
		if (srst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`OFS_WDATA:  prdata <= {16'h0000, wdata};
				`OFS_RDATA:  prdata <= {16'h0000, rdata};
				`OFS_STATUS: prdata <= {29'h0, state == tdm_bit_pkg::H_GUARD, refused,
					state != tdm_bit_pkg::H_IDLE};
				default:     prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			wdata <= 16'h0000;
		else if (psel && penable && pwrite && paddr == `OFS_WDATA)
			wdata <= pwdata[15:0];
	end

	// refusal flag: a new refusal wins over the clear
	always_ff @(posedge core_clk) begin
		if (srst)
			refused <= 1'b0;
		else if (cmd_wr && bad)
			refused <= 1'b1;
		else if (psel && penable && pwrite && paddr == `OFS_STATUS && pwdata[1])
			refused <= 1'b0;
	end

	// frames since connection programming finished
	always_ff @(posedge core_clk) begin
		if (srst || cfg_done)
			settle <= 2'h0;
		else if (frame_start && settle != `SETTLE_FRAMES)
			settle <= settle + 2'h1;
	end

	// ****************************************
	// command sequencer
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state          <= tdm_bit_pkg::H_IDLE;
			lnk.reg_req    <= 1'b0;
			lnk.reg_wr     <= 1'b0;
			lnk.reg_kind   <= 3'h0;
			lnk.reg_stream <= 5'h00;
			lnk.reg_wdata  <= 16'h0000;
			rdata          <= 16'h0000;
		end else begin
			unique case (state)
				tdm_bit_pkg::H_IDLE: begin
					if (cmd_wr && !bad) begin
						lnk.reg_kind   <= pwdata[2:0];
						lnk.reg_stream <= pwdata[12:8];
						lnk.reg_wr     <= pwdata[16];
						lnk.reg_wdata  <= wdata;
						state <= (en_req && settle != `SETTLE_FRAMES) ?
							tdm_bit_pkg::H_GUARD : tdm_bit_pkg::H_ISSUE;
					end
				end
				tdm_bit_pkg::H_GUARD: begin
					if (settle == `SETTLE_FRAMES)
						state <= tdm_bit_pkg::H_ISSUE;
				end
				tdm_bit_pkg::H_ISSUE: begin
					lnk.reg_req <= 1'b1;
					if (lnk.reg_wr && lnk.reg_kind == `KIND_LEN) begin
						if (lnk.reg_wdata[8:0] > max_len)
							lnk.reg_wdata <= {7'h00, max_len};
						else if (lnk.reg_wdata[8:0] == 9'h000)
							lnk.reg_wdata <= {7'h00, `LEN_RST};
					end
					state <= tdm_bit_pkg::H_WAIT;
				end
				tdm_bit_pkg::H_WAIT: begin
					lnk.reg_req <= 1'b0;
					if (lnk.reg_ack) begin
						rdata <= lnk.reg_rdata;
						state <= tdm_bit_pkg::H_IDLE;
					end
				end
			endcase
		end
	end

	// shadows of stream use for the guards and the length limit
	always_ff @(posedge core_clk) begin
		if (srst) begin
			quad_used <= 32'h0000_0000;
			chk_on    <= 32'h0000_0000;
			for (int i = 0; i < 32; i++)
				rate_sh[i] <= 2'h0;
		end else if (state == tdm_bit_pkg::H_ISSUE && lnk.reg_wr) begin
			if (lnk.reg_kind == `KIND_QUAD)
				quad_used[lnk.reg_stream] <= lnk.reg_wdata != 16'h0000;
			if (lnk.reg_kind == `KIND_CTRL)
				chk_on[lnk.reg_stream] <= lnk.reg_wdata[`CTRL_EN_BIT];
			if (lnk.reg_kind == `KIND_RATE)
				rate_sh[lnk.reg_stream] <= lnk.reg_wdata[1:0];
		end
	end

	// ****************************************
	// slot forwarding both ways
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			lnk.slot_valid <= 1'b0;
			lnk.slot_stream <= 5'h00;
			lnk.slot_channel <= 8'h00;
			lnk.rx_byte <= 8'h00;
			lnk.sw_byte <= 8'h00;
			lnk.conn_low <= 3'h0;
			lnk.conn_high <= 5'h00;
			d_valid <= 1'b0;
			d_stream <= 5'h00;
			d_channel <= 8'h00;
			d_tx_byte <= 8'h00;
			d_rx_forced <= 8'h00;
		end else begin
			lnk.slot_valid <= u_valid;
			lnk.slot_stream <= u_stream;
			lnk.slot_channel <= u_channel;
			lnk.rx_byte <= u_rx_byte;
			lnk.sw_byte <= u_sw_byte;
			lnk.conn_low <= u_conn_low;
			lnk.conn_high <= u_conn_high;
			d_valid <= lnk.out_valid;
			d_stream <= lnk.out_stream;
			d_channel <= lnk.out_channel;
			d_tx_byte <= lnk.tx_byte;
			d_rx_forced <= lnk.rx_forced;
		end
	end
endmodule : tdm_bit_host
`default_nettype wire

// ### tb/tdm_bit_properties.sv
// Purpose: link checker for the tdm channel bit processing ends
// Assumes: one clock, synchronous active-high reset
// Notes:   watches only the signals of the link interface
`timescale 1ns/1ps
`default_nettype none
module tdm_bit_properties (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        slot_valid,
	input wire logic [4:0]  slot_stream,
	input wire logic [7:0]  slot_channel,
	input wire logic [7:0]  rx_byte,
	input wire logic [7:0]  sw_byte,
	input wire logic [2:0]  conn_low,
	input wire logic [4:0]  conn_high,
	input wire logic        out_valid,
	input wire logic [4:0]  out_stream,
	input wire logic [7:0]  out_channel,
	input wire logic [7:0]  tx_byte,
	input wire logic [7:0]  rx_forced,
	input wire logic        reg_req,
	input wire logic        reg_wr,
	input wire logic [2:0]  reg_kind,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_ack
);
	// ****************************************
	// helpers and properties
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	logic       gen_on;
	logic [7:0] d_exp;
	function automatic logic [7:0] dmask(input logic [1:0] c);
		return c[1] ? (c[0] ? 8'hFF : 8'hAA) : (c[0] ? 8'h55 : 8'h00);
	endfunction : dmask
	// mirror of the all-generators enable
	always_ff @(posedge core_clk) begin
		if (srst)
			gen_on <= 1'b0;
		else if (reg_req && reg_wr && reg_kind == 3'h0)
			gen_on <= reg_wdata[4];
	end
	// data byte after removing input and applying output inversion
	assign d_exp = sw_byte ^ dmask(conn_high[3:2]) ^ dmask(conn_high[1:0]);
	ack_timing_a: assert property (reg_ack == $past(reg_req))
		else $error("register ack not one cycle after request");
	slot_timing_a: assert property (out_valid == $past(slot_valid))
		else $error("slot result not one cycle after slot");
	slot_tags_a: assert property (out_valid |-> out_stream == $past(slot_stream)
		&& out_channel == $past(slot_channel)) else $error("slot result tags wrong");
	data_law_a: assert property (slot_valid && conn_high[4] && conn_low != 3'b101
		|=> tx_byte == $past(d_exp)) else $error("data coding wrong");
	gen_off_a: assert property (slot_valid && !gen_on && conn_high[4]
		|=> tx_byte == $past(d_exp)) else $error("pattern sent while generators off");
	voice_pass_a: assert property (slot_valid && !conn_high[4] && conn_low != 3'b101
		&& conn_high[3:2] == conn_high[1:0] ##1 out_valid |-> tx_byte == $past(sw_byte))
		else $error("voice byte changed with equal laws");
	force_bits_a: assert property (out_valid |-> ((rx_forced ^ $past(rx_byte)) & 8'h7E)
		== 8'h00) else $error("forcing touched middle bits");
	len_range_a: assert property (reg_ack && $past(reg_kind) == 3'h3
		|-> reg_rdata[15:9] == 7'h00 && reg_rdata[8:0] != 9'h000)
		else $error("length out of range");
	ctrl_bits_a: assert property (reg_ack && $past(reg_kind) == 3'h1
		|-> reg_rdata[15:2] == 14'h0000) else $error("control upper bits set");
	quad_width_a: assert property (reg_ack && $past(reg_kind) == 3'h5
		|-> reg_rdata[15:12] == 4'h0) else $error("quadrant upper bits set");
	cover property (slot_valid && gen_on && conn_low == 3'b101);
	cover property (reg_ack && $past(reg_kind) == 3'h4 && reg_rdata != 16'h0000);
	cover property (out_valid && rx_forced != $past(rx_byte));
endmodule : tdm_bit_properties
`default_nettype wire

// ### tb/tdm_channel_bit_processing_tb.sv
// Purpose: self-checking bench for host and device joined by the link
// Assumes: APB master here, 200 MHz core_clk
// Notes:   fixed seed, results checked at the host user side
`timescale 1ns/1ps
`default_nettype none
`include "tdm_bit_defines.svh"
module tdm_channel_bit_processing_tb;
	// ****************************************
	// bench
	// ****************************************
	logic        core_clk, srst, psel, penable, pwrite, pready, pslverr;
	logic        frame_start, cfg_done, u_valid, d_valid;
	logic [7:0]  paddr, u_channel, u_rx_byte, u_sw_byte, d_channel, d_tx_byte, d_rx_forced;
	logic [31:0] pwdata, prdata, r;
	logic [4:0]  u_stream, u_conn_high, d_stream, ch;
	logic [2:0]  u_conn_low;
	logic [15:0] rd, c1;
	logic [7:0]  tx, fr, sw, b, c;
	logic [11:0] qv;
	logic [63:0] bits;
	integer      seed;
	int          fail_count, checks_done, cyc;
	tdm_bit_if lnk ();
	tdm_bit_device i_tdm_bit_device (.core_clk(core_clk), .srst(srst), .lnk(lnk));
	tdm_bit_host i_tdm_bit_host (.core_clk(core_clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .frame_start(frame_start), .cfg_done(cfg_done),
		.u_valid(u_valid), .u_stream(u_stream), .u_channel(u_channel), .u_rx_byte(u_rx_byte),
		.u_sw_byte(u_sw_byte), .u_conn_low(u_conn_low), .u_conn_high(u_conn_high),
		.d_valid(d_valid), .d_stream(d_stream), .d_channel(d_channel),
		.d_tx_byte(d_tx_byte), .d_rx_forced(d_rx_forced), .lnk(lnk));
	tdm_bit_properties i_props (.core_clk(core_clk), .srst(srst), .slot_valid(lnk.slot_valid),
		.slot_stream(lnk.slot_stream), .slot_channel(lnk.slot_channel), .rx_byte(lnk.rx_byte),
		.sw_byte(lnk.sw_byte), .conn_low(lnk.conn_low), .conn_high(lnk.conn_high),
		.out_valid(lnk.out_valid), .out_stream(lnk.out_stream), .out_channel(lnk.out_channel),
		.tx_byte(lnk.tx_byte), .rx_forced(lnk.rx_forced), .reg_req(lnk.reg_req),
		.reg_wr(lnk.reg_wr), .reg_kind(lnk.reg_kind), .reg_wdata(lnk.reg_wdata),
		.reg_rdata(lnk.reg_rdata), .reg_ack(lnk.reg_ack));
	function automatic logic [7:0] dmask(input logic [1:0] k);
		return k[1] ? (k[0] ? 8'hFF : 8'hAA) : (k[0] ? 8'h55 : 8'h00);
	endfunction : dmask
	function automatic logic [7:0] quad_exp(input logic [2:0] k, input logic [7:0] v);
		if (!k[2])
			return v;
		return k[1] ? {k[0], v[6:0]} : {v[7:1], k[0]};
	endfunction : quad_exp
	function automatic logic prbs_ok(input logic [63:0] q);
		for (int n = 15; n < 64; n++)
			if (q[63-n] !== (q[77-n] ^ q[78-n]))
				return 1'b0;
		return q != 64'h0;
	endfunction : prbs_ok
	task automatic check(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("MISMATCH at %0t: %s", $time, m);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		r = prdata;
		check(pslverr === 1'b0, "slave error");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task automatic dev_issue(input logic w, input logic [2:0] k, input logic [4:0] s,
			input logic [15:0] wd);
		apb(1'b1, `OFS_WDATA, {16'h0000, wd});
		apb(1'b1, `OFS_CMD, {15'h0000, w, 3'h0, s, 5'h00, k});
	endtask : dev_issue
	task automatic dev_finish();
		do
			apb(1'b0, `OFS_STATUS, 32'h0);
		while (r[0] !== 1'b0);
		apb(1'b0, `OFS_RDATA, 32'h0);
		rd = r[15:0];
	endtask : dev_finish
	task automatic dev(input logic w, input logic [2:0] k, input logic [4:0] s,
			input logic [15:0] wd);
		dev_issue(w, k, s, wd);
		dev_finish();
	endtask : dev
	task automatic slot(input logic [4:0] s, input logic [7:0] n, input logic [7:0] rx,
			input logic [7:0] swb, input logic [2:0] cl, input logic [4:0] chh);
		u_valid <= 1'b1;
		u_stream <= s;
		u_channel <= n;
		u_rx_byte <= rx;
		u_sw_byte <= swb;
		u_conn_low <= cl;
		u_conn_high <= chh;
		@(posedge core_clk);
		u_valid <= 1'b0;
		do
			@(posedge core_clk);
		while (d_valid !== 1'b1);
		tx = d_tx_byte;
		fr = d_rx_forced;
		check(d_stream === s && d_channel === n, "slot tags");
	endtask : slot
	task automatic feed(input int lo, input int hi);
		for (int i = lo; i <= hi; i++)
			slot(5'd9, 8'(i), 8'hFF, 8'h00, 3'h0, 5'h00);
	endtask : feed
	// clock and hang limit
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			give_verdict();
		end
	end
	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, frame_start, cfg_done} = '0;
		{u_valid, u_stream, u_channel, u_rx_byte, u_sw_byte, u_conn_low, u_conn_high} = '0;
		seed = 41182;
		srst = 1'b1;
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		dev(1'b0, `KIND_MODE, 5'd0, 16'h0000);
		check(rd === 16'h0000, "mode after reset");
		dev(1'b0, `KIND_LEN, 5'd5, 16'h0000);
		check(rd === 16'h0001, "length after reset");
		apb(1'b0, 8'h10, 32'h0);
		check(r === 32'h0, "unmapped read");
		for (int i = 0; i < 20; i++) begin
			ch = (i < 16) ? {1'b1, 4'(i)} : {1'b0, 2'(i), 2'(i)};
			sw = 8'($random(seed));
			slot(5'(i), 8'($random(seed)), 8'h00, sw, 3'h0, ch);
			check(tx === (ch[4] ? sw ^ dmask(ch[3:2]) ^ dmask(ch[1:0]) : sw), "law");
		end
		slot(5'd2, 8'h01, 8'h00, sw, 3'h0, 5'h02);
		check(tx === (sw ^ 8'h55), "voice even");
		slot(5'd2, 8'h02, 8'h00, sw, 3'h0, 5'h07);
		check(tx === (sw ^ 8'h7F), "voice magnitude");
		for (int p = 0; p < 2; p++) begin
			qv = p ? 12'h688 : 12'hFAC;
			dev(1'b1, `KIND_QUAD, 5'd3, {4'h0, qv});
			dev(1'b0, `KIND_QUAD, 5'd3, 16'h0000);
			check(rd === {4'h0, qv}, "quadrant readback");
			for (int k = 0; k < 4; k++) begin
				dev(1'b1, `KIND_RATE, 5'd3, 16'(k));
				for (int q = 0; q < 4; q++) begin
					c = 8'((q << (3 + k)) + ($random(seed) & ((8 << k) - 1)));
					b = 8'($random(seed));
					slot(5'd3, c, b, b, 3'h0, 5'h00);
					check(fr === quad_exp(3'(qv >> (3 * q)), b), "quadrant force");
				end
			end
		end
		slot(5'd7, 8'h00, 8'h00, 8'h5A, 3'b101, 5'h10);
		check(tx === 8'h5A, "generator idle");
		dev(1'b1, `KIND_MODE, 5'd0, 16'h0030);
		dev(1'b0, `KIND_MODE, 5'd0, 16'h0000);
		check(rd === 16'h0030, "mode readback");
		for (int i = 0; i < 8; i++) begin
			slot(5'd7, 8'(i + 3), 8'h00, 8'($random(seed)), 3'b101, 5'h10);
			bits = {bits[55:0], tx};
		end
		check(prbs_ok(bits), "pattern recurrence");
		dev(1'b1, `KIND_START, 5'd9, 16'h0004);
		dev(1'b1, `KIND_LEN, 5'd9, 16'h0004);
		dev(1'b0, `KIND_START, 5'd9, 16'h0000);
		check(rd === 16'h0004, "start readback");
		cfg_done <= 1'b1;
		@(posedge core_clk);
		cfg_done <= 1'b0;
		dev_issue(1'b1, `KIND_CTRL, 5'd9, 16'h0001);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check(r[2] === 1'b1, "enable held back");
		repeat (2) begin
			frame_start <= 1'b1;
			@(posedge core_clk);
			frame_start <= 1'b0;
			@(posedge core_clk);
		end
		dev_finish();
		feed(0, 3);
		dev(1'b0, `KIND_ERR, 5'd9, 16'h0000);
		check(rd === 16'h0000, "no count outside window");
		feed(4, 7);
		feed(4, 7);
		dev(1'b0, `KIND_ERR, 5'd9, 16'h0000);
		c1 = rd;
		check(c1 != 16'h0000, "errors counted");
		feed(8, 11);
		dev(1'b1, `KIND_ERR, 5'd9, 16'h1234);
		dev(1'b0, `KIND_ERR, 5'd9, 16'h0000);
		check(rd === c1, "count after window and write");
		dev(1'b1, `KIND_CTRL, 5'd9, 16'h0003);
		dev(1'b0, `KIND_ERR, 5'd9, 16'h0000);
		check(rd === 16'h0000, "count cleared");
		dev(1'b1, `KIND_CTRL, 5'd9, 16'h0001);
		dev_issue(1'b1, `KIND_QUAD, 5'd9, 16'h0001);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check(r[1] === 1'b1, "refused");
		u_valid <= 1'b1;
		u_stream <= 5'd9;
		u_rx_byte <= 8'hFF;
		for (int i = 0; i < 9000; i++) begin
			u_channel <= 8'(4 + i % 4);
			@(posedge core_clk);
		end
		u_valid <= 1'b0;
		@(posedge core_clk);
		dev(1'b0, `KIND_ERR, 5'd9, 16'h0000);
		check(rd === `ERR_MAX, "count saturates");
		give_verdict();
	end
endmodule : tdm_channel_bit_processing_tb
`default_nettype wire
